// ### flash_ctl_pkg.sv
// Constants and types for the host-side flash mode and protection controller.
// Assumes a 10 MHz system clock and a byte-wide parallel flash on the pins.
package flash_ctl_pkg;
  localparam int CLK_MHZ = 10;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 8;
  // Strobe low time, well above the device glitch filter
  localparam int STROBE_NS = 200;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int GLITCH_NS = 5;
  // Host register offsets (word index on the command port)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_WDATA = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  localparam logic [3:0] REG_PROT = 4'h5;
  // Control register fields
  localparam int CTRL_GO = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_OP_W = 3;
  localparam int CTRL_IDV = 4;
  localparam int CTRL_TEMPUNP = 5;
  // Autoselect address patterns
  localparam logic [7:0] LOW_MAKER = 8'h00;
  localparam logic [7:0] LOW_PART = 8'h01;
  localparam logic [7:0] LOW_PROT = 8'h02;
  localparam int ID_LINE = 9;
  localparam int GROUP_LSB = 18;
  localparam int GROUPS = 16;
  // Command sequence words
  localparam logic [21:0] UNLOCK1_A = 22'h000555;
  localparam logic [21:0] UNLOCK2_A = 22'h0002AA;
  localparam logic [7:0] UNLOCK1_D = 8'hAA;
  localparam logic [7:0] UNLOCK2_D = 8'h55;
  localparam logic [7:0] AUTOSEL_D = 8'h90;
  localparam logic [7:0] RESET_D = 8'hF0;
  localparam logic [7:0] RESET_STATUS = 8'h00;
  typedef enum logic [2:0] {
    OP_READ, OP_WRITE, OP_ID_HV, OP_AUTOSEL, OP_RESET, OP_SCAN
  } op_t;
endpackage : flash_ctl_pkg

// ### flash_bus_if.sv
// Interface between the sequencer and the pin cycle engine.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
interface flash_bus_if;
  logic req;
  logic wr;
  logic [21:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface : flash_bus_if

// ### flash_cycle_engine.sv
// Runs one read or write cycle on the flash pins.
// Assumes the flash samples its pins asynchronously; outputs are registered.
`timescale 1ns/1ps
module flash_cycle_engine (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Cycle request
  flash_bus_if.eng cyc,
  // Pins
  output logic ceB,
  output logic oeB,
  output logic weB,
  output logic [21:0] addrPins,
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic dataOe
);
  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} eng_t;
  eng_t st_r, st_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic ce_r, ce_nxt, oe_r, oe_nxt, we_r, we_nxt, drv_r, drv_nxt, done_r, done_nxt;
  logic [21:0] a_r, a_nxt;
  logic [7:0] d_r, d_nxt, rd_r, rd_nxt;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    ce_nxt = ce_r;
    oe_nxt = oe_r;
    we_nxt = we_r;
    drv_nxt = drv_r;
    a_nxt = a_r;
    d_nxt = d_r;
    rd_nxt = rd_r;
    done_nxt = 1'b0;
    case (st_r)
      E_IDLE: if (cyc.req) begin
        // Address and data settle before any strobe falls
        a_nxt = cyc.addr;
        d_nxt = cyc.wdata;
        drv_nxt = cyc.wr;
        st_nxt = E_SETUP;
      end
      E_SETUP: begin
        ce_nxt = 1'b0;
        // Output drive stays high through a write; write strobe stays high on a read
        we_nxt = ~drv_r;
        oe_nxt = drv_r;
        cnt_nxt = 8'(flash_ctl_pkg::STROBE_CYC);
        st_nxt = E_STROBE;
      end
      E_STROBE: begin
        // Strobe far longer than the glitch filter width
        if (cnt_r <= 8'h01) begin
          rd_nxt = dataIn;
          we_nxt = 1'b1;
          oe_nxt = 1'b1;
          st_nxt = E_HOLD;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      E_HOLD: begin
        ce_nxt = 1'b1;
        drv_nxt = 1'b0;
        done_nxt = 1'b1;
        st_nxt = E_IDLE;
      end
      default: st_nxt = E_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      // All strobes inactive so no stray write can happen
      st_r <= E_IDLE;
      cnt_r <= 8'h00;
      ce_r <= 1'b1;
      oe_r <= 1'b1;
      we_r <= 1'b1;
      drv_r <= 1'b0;
      a_r <= 22'h000000;
      d_r <= 8'h00;
      rd_r <= 8'h00;
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      ce_r <= ce_nxt;
      oe_r <= oe_nxt;
      we_r <= we_nxt;
      drv_r <= drv_nxt;
      a_r <= a_nxt;
      d_r <= d_nxt;
      rd_r <= rd_nxt;
      done_r <= done_nxt;
    end
  end

  assign ceB = ce_r;
  assign oeB = oe_r;
  assign weB = we_r;
  assign addrPins = a_r;
  assign dataOut = d_r;
  assign dataOe = drv_r;
  assign cyc.done = done_r;
  assign cyc.rdata = rd_r;

  a_write_oe_high: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!weB && !ceB) |-> oeB) else $error("write strobe with output drive low");
  a_strobe_width: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $fell(weB) |-> !weB [*2]) else $error("write strobe too short");
endmodule : flash_cycle_engine

// ### flash_mode_ctl.sv
// Host controller for a byte-wide flash: id readout, autoselect, protection scan.
// Assumes flash pins are synchronous to clk_sys; no device registers exist.
//
// Contract
// - high voltage id: line 9, A0 selects
// - protect check: A1 high, group top bits
// - host keeps strobes at valid levels
// - write needs CE, WE low, OE high
// - host writes reset after flag or autoselect; the controller sends it only on an OP_RESET request
`timescale 1ns/1ps
module flash_mode_ctl (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Flash pins
  output logic ceB,
  output logic oeB,
  output logic weB,
  output logic [21:0] flashAddr,
  input wire logic [7:0] flashDataIn,
  output logic [7:0] flashDataOut,
  output logic flashDataOe,
  // High voltage switches
  output logic idVoltageEn,
  output logic tempUnprotEn
);
  typedef enum logic [2:0] {
    S_IDLE, S_ISSUE, S_WAIT, S_SCAN, S_DONE
  } seq_t;

  flash_bus_if cyc();

  seq_t st_r, st_nxt;
  logic [2:0] op_r, op_nxt;
  logic [21:0] addr_r, addr_nxt;
  logic [7:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [1:0] step_r, step_nxt;
  logic [4:0] grp_r, grp_nxt;
  logic [15:0] prot_r, prot_nxt;
  logic busy_r, busy_nxt, parErr_r, parErr_nxt, idv_r, idv_nxt, tun_r, tun_nxt;
  logic inAutosel_r, inAutosel_nxt, req_r, req_nxt, wr_r, wr_nxt;
  logic [21:0] cycAddr_r, cycAddr_nxt;
  logic [7:0] cycData_r, cycData_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic goCmd;
  logic [21:0] scanAddr;

  assign goCmd = regWr && regAddr == flash_ctl_pkg::REG_CTRL
    && regWdata[flash_ctl_pkg::CTRL_GO] && !busy_r;
  // Group index on the top four lines, A1 high, A0 and A6 low
  assign scanAddr = {grp_r[3:0], 18'h00000} | 22'(flash_ctl_pkg::LOW_PROT);

  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    step_nxt = step_r;
    grp_nxt = grp_r;
    prot_nxt = prot_r;
    busy_nxt = busy_r;
    parErr_nxt = parErr_r;
    idv_nxt = idv_r;
    tun_nxt = tun_r;
    inAutosel_nxt = inAutosel_r;
    req_nxt = 1'b0;
    wr_nxt = wr_r;
    cycAddr_nxt = cycAddr_r;
    cycData_nxt = cycData_r;
    if (regWr && regAddr == flash_ctl_pkg::REG_ADDR) addr_nxt = regWdata[21:0];
    if (regWr && regAddr == flash_ctl_pkg::REG_WDATA) wdata_nxt = regWdata[7:0];
    if (regWr && regAddr == flash_ctl_pkg::REG_CTRL) begin
      // Temporary unprotect only drives the clear pin, stored flags untouched
      tun_nxt = regWdata[flash_ctl_pkg::CTRL_TEMPUNP];
    end
    case (st_r)
      S_IDLE: if (goCmd) begin
        op_nxt = regWdata[flash_ctl_pkg::CTRL_OP_LSB +: flash_ctl_pkg::CTRL_OP_W];
        idv_nxt = regWdata[flash_ctl_pkg::CTRL_IDV];
        busy_nxt = 1'b1;
        step_nxt = 2'h0;
        grp_nxt = 5'h00;
        st_nxt = S_ISSUE;
      end
      S_ISSUE: begin
        req_nxt = 1'b1;
        wr_nxt = 1'b0;
        cycAddr_nxt = addr_r;
        cycData_nxt = wdata_r;
        st_nxt = S_WAIT;
        case (op_r)
          3'(flash_ctl_pkg::OP_WRITE): wr_nxt = 1'b1;
          3'(flash_ctl_pkg::OP_ID_HV): begin
            // Line 9 at high voltage, A6 low, group bits kept for the protection check
            cycAddr_nxt = {addr_r[21:18], 16'h0000, addr_r[1:0]};
            if (addr_r[1]) cycAddr_nxt[0] = 1'b0;
          end
          3'(flash_ctl_pkg::OP_AUTOSEL): begin
            // Two unlock writes then the autoselect command
            wr_nxt = 1'b1;
            case (step_r)
              2'h0: begin
                cycAddr_nxt = flash_ctl_pkg::UNLOCK1_A;
                cycData_nxt = flash_ctl_pkg::UNLOCK1_D;
              end
              2'h1: begin
                cycAddr_nxt = flash_ctl_pkg::UNLOCK2_A;
                cycData_nxt = flash_ctl_pkg::UNLOCK2_D;
              end
              default: begin
                cycAddr_nxt = flash_ctl_pkg::UNLOCK1_A;
                cycData_nxt = flash_ctl_pkg::AUTOSEL_D;
              end
            endcase
          end
          3'(flash_ctl_pkg::OP_RESET): begin
            // Reset command leaves autoselect or a timed-out operation
            wr_nxt = 1'b1;
            cycData_nxt = flash_ctl_pkg::RESET_D;
          end
          3'(flash_ctl_pkg::OP_SCAN): cycAddr_nxt = scanAddr;
          default: ;
        endcase
      end
      S_WAIT: if (cyc.done) begin
        if (op_r == 3'(flash_ctl_pkg::OP_AUTOSEL) && step_r != 2'h2) begin
          step_nxt = step_r + 2'h1;
          st_nxt = S_ISSUE;
        end else if (op_r == 3'(flash_ctl_pkg::OP_SCAN)) begin
          st_nxt = S_SCAN;
        end else begin
          rdata_nxt = cyc.rdata;
          // Group answers are 00 or 01, so only the two id bytes are parity checked
          if ((op_r == 3'(flash_ctl_pkg::OP_ID_HV) && !addr_r[1])
              || (inAutosel_r && op_r == 3'(flash_ctl_pkg::OP_READ)
              && addr_r[7:0] <= flash_ctl_pkg::LOW_PART)) begin
            // Id bytes must show odd parity over all eight bits
            parErr_nxt = ~^cyc.rdata;
          end
          if (op_r == 3'(flash_ctl_pkg::OP_AUTOSEL)) inAutosel_nxt = 1'b1;
          if (op_r == 3'(flash_ctl_pkg::OP_RESET)) inAutosel_nxt = 1'b0;
          st_nxt = S_DONE;
        end
      end
      S_SCAN: begin
        // Bit zero of the answer is the group's protection state
        prot_nxt[grp_r[3:0]] = cyc.rdata[0];
        if (grp_r == 5'(flash_ctl_pkg::GROUPS - 1)) begin
          st_nxt = S_DONE;
        end else begin
          grp_nxt = grp_r + 5'h01;
          st_nxt = S_ISSUE;
        end
      end
      S_DONE: begin
        busy_nxt = 1'b0;
        idv_nxt = 1'b0;
        st_nxt = S_IDLE;
      end
      default: st_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st_r <= S_IDLE;
      op_r <= 3'h0;
      addr_r <= 22'h000000;
      wdata_r <= 8'h00;
      rdata_r <= 8'h00;
      step_r <= 2'h0;
      grp_r <= 5'h00;
      prot_r <= 16'h0000;
      busy_r <= 1'b0;
      parErr_r <= 1'b0;
      idv_r <= 1'b0;
      tun_r <= 1'b0;
      inAutosel_r <= 1'b0;
      req_r <= 1'b0;
      wr_r <= 1'b0;
      cycAddr_r <= 22'h000000;
      cycData_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      step_r <= step_nxt;
      grp_r <= grp_nxt;
      prot_r <= prot_nxt;
      busy_r <= busy_nxt;
      parErr_r <= parErr_nxt;
      idv_r <= idv_nxt;
      tun_r <= tun_nxt;
      inAutosel_r <= inAutosel_nxt;
      req_r <= req_nxt;
      wr_r <= wr_nxt;
      cycAddr_r <= cycAddr_nxt;
      cycData_r <= cycData_nxt;
    end
  end

  assign cyc.req = req_r;
  assign cyc.wr = wr_r;
  assign cyc.addr = cycAddr_r;
  assign cyc.wdata = cycData_r;

  // Read data one cycle after the strobe; unmapped offsets read zero
  always_comb begin
    rd_nxt = 32'h00000000;
    if (regRd) begin
      case (regAddr)
        flash_ctl_pkg::REG_CTRL: rd_nxt = {26'h0, tun_r, idv_r, op_r, 1'b0};
        flash_ctl_pkg::REG_ADDR: rd_nxt = {10'h000, addr_r};
        flash_ctl_pkg::REG_WDATA: rd_nxt = {24'h000000, wdata_r};
        flash_ctl_pkg::REG_STATUS: rd_nxt = {29'h0, inAutosel_r, parErr_r, busy_r};
        flash_ctl_pkg::REG_RDATA: rd_nxt = {24'h000000, rdata_r};
        flash_ctl_pkg::REG_PROT: rd_nxt = {16'h0000, prot_r};
        default: rd_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) rd_r <= 32'h00000000;
    else rd_r <= rd_nxt;
  end

  assign regRdata = rd_r;
  // High voltage on line 9 only for the programmer id method
  assign idVoltageEn = idv_r && op_r == 3'(flash_ctl_pkg::OP_ID_HV);
  assign tempUnprotEn = tun_r;

  flash_cycle_engine engine (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .cyc(cyc.eng),
    .ceB(ceB),
    .oeB(oeB),
    .weB(weB),
    .addrPins(flashAddr),
    .dataIn(flashDataIn),
    .dataOut(flashDataOut),
    .dataOe(flashDataOe)
  );

  a_hv_no_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
    idVoltageEn |-> weB) else $error("write during high voltage id");
  a_scan_addr_ok: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (op_r == 3'(flash_ctl_pkg::OP_SCAN) && !ceB) |-> flashAddr[1:0] == 2'h2 && !flashAddr[6])
    else $error("scan address pattern wrong");
  a_reset_exit: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (st_r == S_WAIT && cyc.done && op_r == 3'(flash_ctl_pkg::OP_RESET)) |=> !inAutosel_r)
    else $error("reset did not leave autoselect");
  a_parity_flag: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (st_r == S_WAIT && cyc.done && op_r == 3'(flash_ctl_pkg::OP_ID_HV) && !addr_r[1])
    |=> parErr_r == ~^rdata_r) else $error("parity flag mismatch");
  a_idle_quiet: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (st_r == S_IDLE && !busy_r) |-> ##1 (ceB || $past(cyc.req)) || st_r != S_IDLE)
    else $error("chip selected while idle");
  a_scan_count: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (st_r == S_SCAN) |-> grp_r < 5'(flash_ctl_pkg::GROUPS)) else $error("group overflow");

  // A group answer of 00 would look like a parity error if it reached the flag
  a_group_no_parity: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (st_r == S_WAIT && cyc.done && op_r == 3'(flash_ctl_pkg::OP_ID_HV) && addr_r[1])
    |=> parErr_r == $past(parErr_r)) else $error("group read changed parity flag");
  a_hv_addr_ok: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (idVoltageEn && !ceB) |-> !flashAddr[6] && !(flashAddr[1] && flashAddr[0]))
    else $error("id address pattern wrong");
  a_read_no_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !oeB |-> weB) else $error("read and write strobes together");
  a_reset_word: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (op_r == 3'(flash_ctl_pkg::OP_RESET) && !weB) |-> flashDataOe
    && flashDataOut == flash_ctl_pkg::RESET_D) else $error("reset word not on the pins");
endmodule : flash_mode_ctl

// ### flash_dev_model.sv
// Behavioural byte-wide flash: array read, command autoselect, high voltage id.
// Assumes the host drives strobes from one clock; no pull on the data lines.
`timescale 1ns/1ps
module flash_dev_model #(
  parameter logic [7:0] MAKER = 8'h07, // Arbitrary value, odd parity
  parameter logic [7:0] PART = 8'h2A, // Arbitrary value, odd parity
  parameter logic [15:0] PROT = 16'h0000
) (
  // Strobes and address
  input wire logic ceB,
  input wire logic oeB,
  input wire logic weB,
  input wire logic [21:0] addr,
  input wire logic idV,
  // Data
  input wire logic [7:0] dIn,
  input wire logic dOe,
  output logic [7:0] dOut
);
  logic [21:0] latAddr;
  logic [1:0] step = 2'h0;
  logic autoSel = 1'b0;
  // A write opens only on a falling strobe, never on levels held from power-up
  logic inWrite = 1'b0;
  realtime tOpen = 0.0;
  logic [7:0] rdVal;
  logic [7:0] lastOut = 8'h00;
  int faults = 0;
  function automatic logic [7:0] id_byte(input logic [21:0] a);
    if (a[1]) return {7'h00, PROT[a[21:18]]};
    return a[0] ? PART : MAKER;
  endfunction : id_byte
  // Both strobes low with output drive high opens a write
  always @(negedge ceB or negedge weB) if (!ceB && !weB && oeB) begin
    latAddr = addr;
    inWrite = 1'b1;
    tOpen = $realtime;
  end
  always @(posedge ceB or posedge weB) if (inWrite) begin
    inWrite = 1'b0;
    // A pulse under the glitch width starts nothing; the host must never make one
    if ($realtime - tOpen < flash_ctl_pkg::GLITCH_NS) faults++;
    else if (dIn == 8'hF0) begin
      autoSel = 1'b0;
      step = 2'h0;
    end else if (step == 2'h0 && latAddr[10:0] == 11'h555 && dIn == 8'hAA) step = 2'h1;
    else if (step == 2'h1 && latAddr[10:0] == 11'h2AA && dIn == 8'h55) step = 2'h2;
    else if (step == 2'h2 && latAddr[10:0] == 11'h555 && dIn == 8'h90) begin
      autoSel = 1'b1;
      step = 2'h0;
    end else begin
      autoSel = 1'b0;
      step = 2'h0;
    end
  end
  // Host must never read and write, or drive data, at once
  always @(negedge weB or negedge oeB or posedge dOe)
    if (!ceB && !oeB && (!weB || dOe)) faults++;
  always @* begin
    if (idV && !addr[6]) rdVal = id_byte(addr);
    else if (autoSel && addr[7:0] < 8'h03) rdVal = id_byte(addr);
    else rdVal = addr[7:0] ^ addr[15:8];
  end
  // Released lines show the inverse so stale data cannot pass
  always @(rdVal or ceB or oeB) if (!ceB && !oeB) lastOut = rdVal;
  assign dOut = (!ceB && !oeB) ? rdVal : ~lastOut;
endmodule : flash_dev_model

// ### flash_mode_ctl_bench.sv
// Self-checking bench for the flash mode controller over its register port.
// Assumes the device model above stands on the flash pins.
`timescale 1ns/1ps
module flash_mode_ctl_bench;
  localparam logic [7:0] MAKER = 8'h07; // Arbitrary identification value
  localparam logic [7:0] PART = 8'h2A; // Arbitrary identification value
  localparam logic [15:0] PROT = 16'hA005;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata;
  logic ceB, oeB, weB, flashDataOe, idVoltageEn, tempUnprotEn;
  logic [21:0] flashAddr;
  logic [7:0] flashDataOut, devOut, dqWire;
  int bad_count = 0;
  int n_compared = 0;
  logic [21:0] seqA [6] = '{22'h000555, 22'h0002AA, 22'h000555, 22'h000555, 22'h0002AA,
    22'h000555};
  logic [7:0] seqD [6] = '{8'hAA, 8'h55, 8'h90, 8'hAA, 8'h55, 8'h33};
  always #50 clk_sys = ~clk_sys;
  assign dqWire = flashDataOe ? flashDataOut : devOut;
  flash_mode_ctl flash_mode_ctl_i (.clk_sys(clk_sys), .rst_b(rst_b), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .ceB(ceB),
    .oeB(oeB), .weB(weB), .flashAddr(flashAddr), .flashDataIn(dqWire),
    .flashDataOut(flashDataOut), .flashDataOe(flashDataOe), .idVoltageEn(idVoltageEn),
    .tempUnprotEn(tempUnprotEn));
  flash_dev_model #(.MAKER(MAKER), .PART(PART), .PROT(PROT)) flash_dev_model_i (.ceB(ceB),
    .oeB(oeB), .weB(weB), .addr(flashAddr), .idV(idVoltageEn), .dIn(dqWire),
    .dOe(flashDataOe), .dOut(devOut));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report();
    if (bad_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : reg_read
  // Busy is polled a bounded number of times; a hang ends the run
  task automatic run_op(input flash_ctl_pkg::op_t op, input logic [21:0] a, input logic idv);
    logic [31:0] st;
    reg_write(flash_ctl_pkg::REG_ADDR, {10'h000, a});
    reg_write(flash_ctl_pkg::REG_CTRL, {26'h0, 1'b0, idv, op, 1'b1});
    for (int i = 0; i < 100; i++) begin
      reg_read(flash_ctl_pkg::REG_STATUS, st);
      if (st[0] === 1'b0) return;
    end
    check("busy", st, 32'h0);
    final_report();
  endtask : run_op
  task automatic flash_read(input logic [21:0] a, input logic idv, input logic [7:0] exp,
    input string what);
    logic [31:0] d;
    run_op(idv ? flash_ctl_pkg::OP_ID_HV : flash_ctl_pkg::OP_READ, a, idv);
    reg_read(flash_ctl_pkg::REG_RDATA, d);
    check(what, d, {24'h0, exp});
  endtask : flash_read
  initial begin
    logic [31:0] d;
    repeat (3) @(posedge clk_sys);
    #1 check("idle pins", {26'h0, ceB, oeB, weB, flashDataOe, idVoltageEn, tempUnprotEn},
      32'h38);
    rst_b <= 1'b1;
    flash_read(22'h012345, 1'b0, 8'h66, "array read");
    reg_read(flash_ctl_pkg::REG_STATUS, d);
    check("status", d & 32'h7, 32'h0);
    flash_read(22'h3FFDBC, 1'b1, MAKER, "hv maker");
    flash_read(22'h2AB8BD, 1'b1, PART, "hv part");
    reg_read(flash_ctl_pkg::REG_STATUS, d);
    check("parity flag", d & 32'h2, 32'h0);
    for (int g = 0; g < 16; g++)
      flash_read({g[3:0], 18'h0C002}, 1'b1, {7'h0, PROT[g]}, "hv group");
    reg_read(flash_ctl_pkg::REG_STATUS, d);
    check("parity after groups", d & 32'h2, 32'h0);
    run_op(flash_ctl_pkg::OP_AUTOSEL, 22'h000000, 1'b0);
    reg_read(flash_ctl_pkg::REG_STATUS, d);
    check("autoselect flag", d & 32'h4, 32'h4);
    flash_read(22'h155500, 1'b0, MAKER, "cmd maker");
    flash_read(22'h2AAA01, 1'b0, PART, "cmd part");
    flash_read(22'h3C0002, 1'b0, {7'h0, PROT[15]}, "cmd group");
    flash_read(22'h050002, 1'b0, {7'h0, PROT[1]}, "cmd group");
    run_op(flash_ctl_pkg::OP_SCAN, 22'h000000, 1'b0);
    reg_read(flash_ctl_pkg::REG_PROT, d);
    check("scan flags", d, {16'h0, PROT});
    run_op(flash_ctl_pkg::OP_RESET, 22'h000000, 1'b0);
    reg_read(flash_ctl_pkg::REG_STATUS, d);
    check("autoselect flag", d & 32'h4, 32'h0);
    flash_read(22'h000102, 1'b0, 8'h03, "array after reset");
    // Raw write cycles: a full unlock enters autoselect, a bad third word leaves it
    for (int k = 0; k < 6; k++) begin
      reg_write(flash_ctl_pkg::REG_WDATA, {24'h0, seqD[k]});
      run_op(flash_ctl_pkg::OP_WRITE, seqA[k], 1'b0);
      if (k == 2) flash_read(22'h000300, 1'b0, MAKER, "raw autoselect");
    end
    flash_read(22'h000300, 1'b0, 8'h03, "aborted sequence");
    reg_write(flash_ctl_pkg::REG_CTRL, 32'h20);
    #1 check("temp unprotect", {31'h0, tempUnprotEn}, 32'h1);
    reg_write(flash_ctl_pkg::REG_CTRL, 32'h0);
    #1 check("temp unprotect", {31'h0, tempUnprotEn}, 32'h0);
    reg_read(4'hF, d);
    check("unmapped read", d, 32'h0);
    check("strobe faults", flash_dev_model_i.faults, 32'h0);
    final_report();
  end
endmodule : flash_mode_ctl_bench
